// [mmfv_cfg.svh]
`ifndef MMFV_CFG_SVH
`define MMFV_CFG_SVH

// byte offsets of the bank inside the lower management region
`define MMFV_OFS_TEMP_FLAGS   8'h06
`define MMFV_OFS_VCC_FLAGS    8'h07
`define MMFV_OFS_RXP_CH12     8'h09
`define MMFV_OFS_RXP_CH34     8'h0A
`define MMFV_OFS_BIAS_CH12    8'h0B
`define MMFV_OFS_BIAS_CH34    8'h0C
`define MMFV_OFS_TXP_CH12     8'h0D
`define MMFV_OFS_TXP_CH34     8'h0E
`define MMFV_OFS_TEMP_HIGH    8'h16
`define MMFV_OFS_TEMP_LOW     8'h17
`define MMFV_OFS_VCC_HIGH     8'h1A
`define MMFV_OFS_VCC_LOW      8'h1B

// module flag bytes use only the upper nibble
`define MMFV_MOD_FLAG_MASK    8'hF0
`define MMFV_CH_FLAG_MASK     8'hFF
`define MMFV_FLAG_BYTES       8
`define MMFV_IDX_TEMP         3'h0
`define MMFV_IDX_VCC          3'h1
`define MMFV_IDX_RXP12        3'h2

// serial bus framing
`define MMFV_DEV_ADDR         7'h50
`define MMFV_BITS_PER_BYTE    4'h8
`define MMFV_LAST_RD_SHIFT    4'h7
`define MMFV_ZERO_BYTE        8'h00
`define MMFV_SYNC_IDLE        3'h7

`endif

// [mmfv_pkg.sv]
package mmfv_pkg;

	// one byte per flag register, index 0 = temperature flags
	typedef logic [7:0] mmfv_byte_t;
	typedef mmfv_byte_t [7:0] mmfv_flag_bank_t;

	typedef struct packed {
		logic signed [15:0] temp;  // 1/256 degC per step
		logic        [15:0] volt;  // 100 uV per step
	} mmfv_mon_t;

	typedef enum logic [2:0] {
		MMFV_IDLE,
		MMFV_ADDR,
		MMFV_ACK_ADDR,
		MMFV_WR,
		MMFV_ACK_WR,
		MMFV_RD,
		MMFV_ACK_RD
	} mmfv_state_t;

endpackage

// [mmfv_bank.sv]
`timescale 1ns/1ps
`include "mmfv_cfg.svh"

// Functional notes
// - byte 6 holds latched temperature flags in bits 7..4, low nibble reserved.
// - byte 7 holds latched supply flags in bits 7..4, low nibble reserved.
// - byte 9 holds receive power flags, channel 1 high nibble, channel 2 low.
// - byte 10 holds receive power flags, channel 3 high nibble, channel 4 low.
// - bytes 11 and 12 hold transmit bias flags, lower channel in high nibble.
// - bytes 13 and 14 hold transmit power flags, same placement as bias.
// - temperature is a signed 16-bit word, 1/256 degree per step.
// - temperature high byte at 22, low byte at 23.
// - supply voltage is an unsigned 16-bit word, 100 microvolts per step.
// - supply voltage high byte at 26, low byte at 27.
// - a flag reads 0 until its condition occurs, sets on the condition and stays set until read.
// - the bank is read over the always addressable lower 128 byte region.
// - any unmasked latched flag drives the interrupt output low.
// - not ready stays high until valid readings exist, then stays low.
module mmfv_bank
	import mmfv_pkg::*;
(
	input  wire logic            CLK,              // 100 MHz clock
	input  wire logic            RST_N,            // sync reset, active low
	input  wire logic            SCL_I,            // serial clock pin
	input  wire logic            SDA_I,            // serial data pin level
	output logic                 SDA_O,            // data drive value, always 0
	output logic                 SDA_OE,           // high while pulling low
	input  wire mmfv_flag_bank_t COND,             // live flag conditions
	input  wire mmfv_flag_bank_t MASK,             // 1 = event masked
	input  wire logic            MEAS_VALID,       // new readings strobe
	input  wire mmfv_mon_t       MEAS,             // readings with strobe
	output logic                 INTERRUPT_OUT_N,  // open-drain level, low
	output logic                 DATA_NOT_READY    // no valid readings yet
);

	logic [2:0]      scl_sync;
	logic [2:0]      sda_sync;
	logic            scl_f;
	logic            sda_f;
	logic            scl_p;
	logic            sda_p;
	mmfv_state_t     state;
	logic [3:0]      bit_cnt;
	logic [7:0]      shift;
	logic [7:0]      ptr;
	logic            first_wr;
	logic            master_nack;
	mmfv_flag_bank_t flags;
	mmfv_mon_t       mon;

	wire logic scl_rise   = scl_f & ~scl_p;
	wire logic scl_fall   = ~scl_f & scl_p;
	wire logic start_seen = scl_f & scl_p & sda_p & ~sda_f;
	wire logic stop_seen  = scl_f & scl_p & ~sda_p & sda_f;
	wire logic byte_done  = (bit_cnt == `MMFV_BITS_PER_BYTE);
	wire logic addr_hit   = (shift[7:1] == `MMFV_DEV_ADDR);

	// load of a read byte; this is what clears the flags it carries
	wire logic rd_load = scl_fall &
		(((state == MMFV_ACK_ADDR) & shift[0]) |
		 ((state == MMFV_ACK_RD) & ~master_nack));

	function automatic logic [3:0] flag_slot(input logic [7:0] a);
		case (a)
			`MMFV_OFS_TEMP_FLAGS: flag_slot = 4'h8;
			`MMFV_OFS_VCC_FLAGS:  flag_slot = 4'h9;
			`MMFV_OFS_RXP_CH12:   flag_slot = 4'hA;
			`MMFV_OFS_RXP_CH34:   flag_slot = 4'hB;
			`MMFV_OFS_BIAS_CH12:  flag_slot = 4'hC;
			`MMFV_OFS_BIAS_CH34:  flag_slot = 4'hD;
			`MMFV_OFS_TXP_CH12:   flag_slot = 4'hE;
			`MMFV_OFS_TXP_CH34:   flag_slot = 4'hF;
			default:              flag_slot = 4'h0;
		endcase
	endfunction

	// bit 3 of the slot marks a flag byte, bits 2..0 its index
	wire logic [3:0] rd_slot  = flag_slot(ptr);
	wire logic       rd_flag  = rd_slot[3];
	wire logic [2:0] rd_index = rd_slot[2:0];

	// bytes above 127 and unlisted bytes fall through to zero
	wire logic [7:0] rd_data =
		ptr[7]                      ? `MMFV_ZERO_BYTE :
		rd_flag                     ? flags[rd_index] :
		(ptr == `MMFV_OFS_TEMP_HIGH) ? mon.temp[15:8] :
		(ptr == `MMFV_OFS_TEMP_LOW)  ? mon.temp[7:0] :
		(ptr == `MMFV_OFS_VCC_HIGH)  ? mon.volt[15:8] :
		(ptr == `MMFV_OFS_VCC_LOW)   ? mon.volt[7:0] :
		`MMFV_ZERO_BYTE;

	// three stage pin synchroniser, a change counts when 2nd and 3rd agree
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			scl_sync <= `MMFV_SYNC_IDLE;
			sda_sync <= `MMFV_SYNC_IDLE;
		end else begin
			scl_sync <= {scl_sync[1:0], SCL_I};
			sda_sync <= {sda_sync[1:0], SDA_I};
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			if (scl_sync[1] == scl_sync[2]) begin
				scl_f <= scl_sync[2];
			end
			if (sda_sync[1] == sda_sync[2]) begin
				sda_f <= sda_sync[2];
			end
			scl_p <= scl_f;
			sda_p <= sda_f;
		end
	end

	// serial slave; data changes only after scl falls
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state       <= MMFV_IDLE;
			bit_cnt     <= 4'h0;
			shift       <= `MMFV_ZERO_BYTE;
			ptr         <= `MMFV_ZERO_BYTE;
			first_wr    <= 1'b0;
			master_nack <= 1'b1;
			SDA_OE      <= 1'b0;
		end else if (start_seen) begin
			state   <= MMFV_ADDR;
			bit_cnt <= 4'h0;
			SDA_OE  <= 1'b0;
		end else if (stop_seen) begin
			state  <= MMFV_IDLE;
			SDA_OE <= 1'b0;
		end else begin
			case (state)
				MMFV_IDLE: begin
					SDA_OE <= 1'b0;
				end
				MMFV_ADDR, MMFV_WR: begin
					if (scl_rise && !byte_done) begin
						shift   <= {shift[6:0], sda_f};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						bit_cnt <= 4'h0;
						if (state == MMFV_ADDR) begin
							state  <= addr_hit ? MMFV_ACK_ADDR : MMFV_IDLE;
							SDA_OE <= addr_hit;
						end else begin
							// data bytes only move the pointer
							state    <= MMFV_ACK_WR;
							SDA_OE   <= 1'b1;
							first_wr <= 1'b0;
							ptr      <= first_wr ? shift : ptr + 8'h01;
						end
					end
				end
				MMFV_ACK_ADDR: begin
					if (scl_fall) begin
						if (shift[0]) begin
							state   <= MMFV_RD;
							shift   <= rd_data;
							SDA_OE  <= ~rd_data[7];
							ptr     <= ptr + 8'h01;
							bit_cnt <= 4'h0;
						end else begin
							state    <= MMFV_WR;
							SDA_OE   <= 1'b0;
							first_wr <= 1'b1;
						end
					end
				end
				MMFV_ACK_WR: begin
					if (scl_fall) begin
						state  <= MMFV_WR;
						SDA_OE <= 1'b0;
					end
				end
				MMFV_RD: begin
					if (scl_fall) begin
						if (bit_cnt == `MMFV_LAST_RD_SHIFT) begin
							state  <= MMFV_ACK_RD;
							SDA_OE <= 1'b0;
						end else begin
							shift   <= {shift[6:0], 1'b0};
							SDA_OE  <= ~shift[6];
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				MMFV_ACK_RD: begin
					if (scl_rise) begin
						master_nack <= sda_f;
					end else if (scl_fall) begin
						if (master_nack) begin
							state <= MMFV_IDLE;
						end else begin
							state   <= MMFV_RD;
							shift   <= rd_data;
							SDA_OE  <= ~rd_data[7];
							ptr     <= ptr + 8'h01;
							bit_cnt <= 4'h0;
						end
					end
				end
				default: begin
					state  <= MMFV_IDLE;
					SDA_OE <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			SDA_O <= 1'b0;
		end else begin
			SDA_O <= 1'b0;
		end
	end

	// sticky flags: a condition in the clearing cycle wins over the read
	genvar gi;
	generate
		for (gi = 0; gi < `MMFV_FLAG_BYTES; gi++) begin : g_flag
			localparam logic [7:0] KEEP = (gi < 2) ?
				`MMFV_MOD_FLAG_MASK : `MMFV_CH_FLAG_MASK;
			wire logic clr = rd_load & rd_flag & (rd_index == 3'(gi));
			wire logic [7:0] next_flag =
				((clr ? `MMFV_ZERO_BYTE : flags[gi]) | COND[gi]) & KEEP;
			always_ff @(posedge CLK) begin
				if (!RST_N) begin
					flags[gi] <= `MMFV_ZERO_BYTE;
				end else begin
					flags[gi] <= next_flag;
				end
			end
		end
	endgenerate

	wire logic next_int_n = ~|(flags & ~MASK);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			INTERRUPT_OUT_N <= 1'b1;
			DATA_NOT_READY  <= 1'b1;
			mon             <= '0;
		end else begin
			INTERRUPT_OUT_N <= next_int_n;
			if (MEAS_VALID) begin
				DATA_NOT_READY <= 1'b0;
				mon            <= MEAS;
			end
		end
	end

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_temp_reserved: assert property (flags[`MMFV_IDX_TEMP][3:0] == 4'h0)
		else $error("temperature flag low nibble not zero");
	a_vcc_reserved: assert property (flags[`MMFV_IDX_VCC][3:0] == 4'h0)
		else $error("supply flag low nibble not zero");
	a_cond_latch: assert property (COND[`MMFV_IDX_RXP12][7]
		|=> flags[`MMFV_IDX_RXP12][7])
		else $error("condition did not set its flag");
	a_flag_sticky: assert property (flags != '0 && !rd_load && COND == '0
		|=> flags == $past(flags))
		else $error("flag changed without a read");
	a_read_clears: assert property (rd_load && rd_flag && COND == '0
		|=> flags[$past(rd_index)] == 8'h00)
		else $error("read did not clear flag byte");
	a_flag_idle: assert property ($past(COND) == '0 && $past(flags) == '0
		|-> flags == '0)
		else $error("flag set without a condition");
	a_int_low: assert property ((flags & ~MASK) != '0
		|=> !INTERRUPT_OUT_N)
		else $error("interrupt not driven on unmasked flag");
	a_int_high: assert property ((flags & ~MASK) == '0
		|=> INTERRUPT_OUT_N)
		else $error("interrupt active with no unmasked flag");
	a_ready_once: assert property (!DATA_NOT_READY |=> !DATA_NOT_READY)
		else $error("not ready returned high");
	a_ready_cause: assert property ($fell(DATA_NOT_READY)
		|-> $past(MEAS_VALID))
		else $error("not ready cleared without readings");
	a_temp_word: assert property (MEAS_VALID
		|=> mon.temp == $past(MEAS.temp) && mon.volt == $past(MEAS.volt))
		else $error("monitor word not captured");
	a_temp_high: assert property (rd_load && ptr == `MMFV_OFS_TEMP_HIGH
		|=> shift == $past(mon.temp[15:8]))
		else $error("temperature high byte misplaced");
	a_vcc_low: assert property (rd_load && ptr == `MMFV_OFS_VCC_LOW
		|=> shift == $past(mon.volt[7:0]))
		else $error("supply low byte misplaced");
	a_upper_zero: assert property (rd_load && ptr[7]
		|=> shift == 8'h00)
		else $error("byte above region not zero");
	a_rsvd_zero: assert property (rd_load && !ptr[7] && !rd_flag
		&& ptr != `MMFV_OFS_TEMP_HIGH && ptr != `MMFV_OFS_TEMP_LOW
		&& ptr != `MMFV_OFS_VCC_HIGH && ptr != `MMFV_OFS_VCC_LOW
		|=> shift == 8'h00)
		else $error("reserved byte not zero");

	c_read_flag: cover property (rd_load && rd_flag && flags[rd_index] != 0);
	c_int_fire: cover property ($fell(INTERRUPT_OUT_N));
	c_ready: cover property ($fell(DATA_NOT_READY));
	c_wr_ptr: cover property (state == MMFV_ACK_WR ##1 state == MMFV_WR);
	c_set_clear: cover property (rd_load && rd_flag && COND[rd_index] != 0);

endmodule

// [mmfv_host.sv]
`timescale 1ns/1ps
`include "mmfv_cfg.svh"

module mmfv_host (
	input  wire logic clk,   // bench clock
	input  wire logic sda,   // resolved data wire
	output logic      scl,   // serial clock drive
	output logic      sda_m  // 0 pulls low, 1 lets the pull-up win
);
	logic [7:0] rdat [0:15];
	logic       nak;

	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		nak = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask

	// data moves well after the clock fall so the filter sees no start
	task automatic bitx(input logic b, output logic r);
		sda_m = b;
		wt(8);
		scl = 1'b1;
		wt(5);
		r = sda;
		wt(4);
		scl = 1'b0;
		wt(4);
	endtask

	task automatic xfer(input logic [7:0] w, input logic a,
			output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
		bitx(a, k);
	endtask

	task automatic start;
		sda_m = 1'b1;
		wt(8);
		scl = 1'b1;
		wt(8);
		sda_m = 1'b0;
		wt(8);
		scl = 1'b0;
		wt(4);
	endtask

	task automatic stop;
		sda_m = 1'b0;
		wt(8);
		scl = 1'b1;
		wt(8);
		sda_m = 1'b1;
		wt(8);
	endtask

	task automatic hdr(input logic [7:0] ptr);
		logic [7:0] d;
		logic       k;
		start;
		xfer({`MMFV_DEV_ADDR, 1'b0}, 1'b1, d, k);
		nak = k;
		xfer(ptr, 1'b1, d, k);
		nak = nak | k;
	endtask

	task automatic rd(input logic [7:0] ptr, input int n);
		logic [7:0] d;
		logic       k;
		hdr(ptr);
		start;
		xfer({`MMFV_DEV_ADDR, 1'b1}, 1'b1, d, k);
		nak = nak | k;
		for (int i = 0; i < n; i++) xfer(8'hFF, i == n - 1, rdat[i], k);
		stop;
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
		logic [7:0] d;
		logic       k;
		hdr(ptr);
		xfer(v, 1'b1, d, k);
		stop;
	endtask
endmodule

// [module_monitor_flag_and_value_bank_tb.sv]
`timescale 1ns/1ps

module module_monitor_flag_and_value_bank_tb
	import mmfv_pkg::*;
;
	logic            clk, rst_n, scl, sda_m, sda, sda_oe;
	logic            int_n, not_rdy, meas_valid;
	mmfv_flag_bank_t cond, mask;
	mmfv_mon_t       meas;
	int              err_count, n_tests, t_exp, v_exp;
	int              exp_f [0:7];

	assign sda = sda_oe ? 1'b0 : sda_m;

	mmfv_bank DUT (.CLK(clk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda),
		.SDA_O(), .SDA_OE(sda_oe), .COND(cond), .MASK(mask),
		.MEAS_VALID(meas_valid), .MEAS(meas), .INTERRUPT_OUT_N(int_n),
		.DATA_NOT_READY(not_rdy));
	mmfv_host host (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] e,
			input logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask

	function automatic int fidx(int a);
		if (a == 6 || a == 7) return a - 6;
		if (a >= 9 && a <= 14) return a - 7;
		return -1;
	endfunction

	function automatic logic [7:0] ebyte(int a);
		if (fidx(a) >= 0) return exp_f[fidx(a)][7:0];
		case (a)
			22: return t_exp[15:8];
			23: return t_exp[7:0];
			26: return v_exp[15:8];
			27: return v_exp[7:0];
			default: return 8'h00;
		endcase
	endfunction

	task automatic rdchk(input int a, input int n);
		host.rd(a[7:0], n);
		chk("address ack", 16'h0000, {15'h0000, host.nak});
		for (int i = 0; i < n; i++) begin
			chk($sformatf("byte %0d", a + i), ebyte(a + i), host.rdat[i]);
			if (fidx(a + i) >= 0) exp_f[fidx(a + i)] = 0;
		end
	endtask

	// module flag bytes keep their low nibble reserved
	task automatic fire(input mmfv_flag_bank_t c);
		@(negedge clk) cond = c;
		@(negedge clk) cond = '0;
		for (int k = 0; k < 8; k++)
			exp_f[k] |= c[k] & ((k < 2) ? 8'hF0 : 8'hFF);
	endtask

	task automatic intchk;
		logic any;
		any = 1'b0;
		repeat (3) @(negedge clk);
		for (int k = 0; k < 8; k++) any |= (exp_f[k][7:0] & ~mask[k]) != 0;
		chk("interrupt", {15'h0000, !any}, {15'h0000, int_n});
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#900000;
		err_count++;
		give_verdict;
	end

	initial begin
		void'($urandom(32'h7240B758));
		{rst_n, meas_valid, cond, mask, meas} = '0;
		{err_count, n_tests, t_exp, v_exp} = '0;
		for (int k = 0; k < 8; k++) exp_f[k] = 0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk("not ready", 16'h0001, {15'h0000, not_rdy});
		chk("interrupt", 16'h0001, {15'h0000, int_n});
		rdchk(6, 9);
		$display("test reset done");
		repeat (2) begin
			fire({$urandom, $urandom});
			intchk;
			rdchk(6, 9);
			rdchk(6, 9);
			intchk;
		end
		$display("test flags done");
		@(negedge clk) mask = '1;
		fire(64'h0000_0000_0000_0080);
		intchk;
		@(negedge clk) mask = '0;
		intchk;
		rdchk(6, 1);
		intchk;
		$display("test mask done");
		repeat (3) begin
			t_exp = $urandom & 32'h0000FFFF;
			v_exp = $urandom & 32'h0000FFFF;
			@(negedge clk) meas = {t_exp[15:0], v_exp[15:0]};
			meas_valid = 1'b1;
			@(negedge clk) meas_valid = 1'b0;
			@(negedge clk);
			chk("not ready", 16'h0000, {15'h0000, not_rdy});
			rdchk(22, 12);
		end
		$display("test readings done");
		fire(64'h0000_0000_0000_000F);
		host.wr(8'h06, 8'hFF);
		host.wr(8'h08, 8'h5A);
		rdchk(6, 3);
		rdchk(126, 4);
		$display("test writes done");
		give_verdict;
	end
endmodule
